// [src/pmsnap_regs.v]
// performance monitor snapshot register bank on the external debug port
// Functional notes
// [RULE_01] the pc snapshot reads the live pc sample with no read side effect
// [RULE_02] pc snapshot is 64 bits: ns flag 63, level 62:61, zero 60:56, pc
// [RULE_03] any snapshot access errors while power is off or double locked
// [RULE_04] status is read-only, bit 0 is no-capture, bits 31:1 read zero
// [RULE_05] a capture under security violation stores no counters, nc=1
// [RULE_06] the no-capture flag ignores whether the pc sample was captured
// [RULE_07] warm reset sets no-capture to 1, the next capture overwrites it
// [RULE_08] overflow snapshot is unaffected by later set or clear writes
// [RULE_09] cycle snapshot is unaffected by later counter or reset writes
// [RULE_10] six event snapshots copy their counters and then stay fixed
// [RULE_11] trigger is write-only, bit 0 at 1 captures, 0 is ignored
// [RULE_12] context snapshots read the live el1 and el2 context samples
// [RULE_13] the monitor tracks its own capture success, not this bank
// [RULE_14] registers sit at 0x600 to 0x61c, 0x620 + 4n and 0x6f0
// [RULE_15] one capture loads all counter snapshots on the same cycle
`timescale 1ns/10ps
`include "pmsnap_defs.vh"

module pmsnap_regs #(
  parameter EVT_N   = `PMSNAP_EVT_COUNT,
  parameter ADDR_W  = 12,
  parameter CNT_W   = 32
) (
  input  wire                 clk,
  input  wire                 rst_b,
  // external debug access port
  input  wire                 dbg_sel,
  input  wire                 dbg_write,
  input  wire [ADDR_W-1:0]    dbg_addr,
  input  wire [31:0]          dbg_wdata,
  output reg                  dbg_ready,
  output reg                  dbg_error,
  output reg  [31:0]          dbg_rdata,
  // core state
  input  wire                 core_power_on,
  input  wire                 double_lock_active,
  input  wire                 security_violation,
  // live sample registers
  input  wire                 nonsecure_sample_flag,
  input  wire [1:0]           exception_level_sample,
  input  wire [55:0]          live_pc_sample,
  input  wire [31:0]          live_ctx_el1_sample,
  input  wire [31:0]          live_ctx_el2_sample,
  // live counters
  input  wire [31:0]          overflow_status,
  input  wire [63:0]          cycle_counter,
  input  wire [EVT_N*CNT_W-1:0] event_counter,
  // capture strobe towards the core, one cycle
  output reg                  capture_pulse
);

  // ======================================================================
  // access decode
  wire                 access_blocked;
  wire                 take;
  wire                 trig_hit;
  wire                 capture_req;
  wire                 counters_load;
  wire [ADDR_W-1:0]    evt_off;
  wire [ADDR_W-1:0]    evt_idx_full;
  wire                 evt_range;
  wire [`PMSNAP_EVT_IDX_W-1:0] evt_idx;
  wire [63:0]          pc_view;
  wire [31:0]          ovf_held;
  wire [63:0]          cyc_held;
  wire [EVT_N*CNT_W-1:0] evt_held;
  reg                  no_capture;
  reg  [31:0]          next_rdata;
  reg                  next_error;

  // status and all snapshots are gated by the same power and lock check
  assign access_blocked = !core_power_on || double_lock_active; // RULE_03
  assign take           = dbg_sel && !dbg_ready;
  assign trig_hit       = (dbg_addr == `PMSNAP_OFF_TRIGGER);
  assign capture_req    = take && dbg_write && trig_hit && !access_blocked
                          && dbg_wdata[`PMSNAP_TRIG_SS_BIT]; // RULE_11
  // a violating capture leaves the old counter copies in place
  assign counters_load  = capture_req && !security_violation; // RULE_05

  assign evt_off      = dbg_addr - `PMSNAP_OFF_EVT_BASE;
  assign evt_idx_full = evt_off >> `PMSNAP_WORD_SHIFT;
  assign evt_range    = (dbg_addr >= `PMSNAP_OFF_EVT_BASE)
                        && (evt_idx_full < EVT_N)
                        && (dbg_addr[1:0] == 2'b00); // RULE_14
  assign evt_idx      = evt_idx_full[`PMSNAP_EVT_IDX_W-1:0];

  // ======================================================================
  // pc view: combinational on the live sample, so reads cause no sample
  assign pc_view = {nonsecure_sample_flag,
                    exception_level_sample,
                    `PMSNAP_ZERO5,
                    live_pc_sample}; // RULE_01 RULE_02

  // ======================================================================
  // counter copies, all loaded by the same strobe
  pmsnap_capture_reg #(.WIDTH(32)) u_ovf (
    .clk   (clk),
    .rst_b (rst_b),
    .load  (counters_load), // RULE_15
    .src   (overflow_status),
    .held  (ovf_held)
  ); // RULE_08

  pmsnap_capture_reg #(.WIDTH(64)) u_cyc (
    .clk   (clk),
    .rst_b (rst_b),
    .load  (counters_load), // RULE_15
    .src   (cycle_counter),
    .held  (cyc_held)
  ); // RULE_09

  genvar gi;
  generate
    for (gi = 0; gi < EVT_N; gi = gi + 1) begin : g_evt
      pmsnap_capture_reg #(.WIDTH(CNT_W)) u_evt (
        .clk   (clk),
        .rst_b (rst_b),
        .load  (counters_load), // RULE_15
        .src   (event_counter[gi*CNT_W +: CNT_W]),
        .held  (evt_held[gi*CNT_W +: CNT_W])
      ); // RULE_10
    end
  endgenerate

  // ======================================================================
  // no-capture flag, counters only, pc capture has no say
  always @(posedge clk) begin
    if (!rst_b) begin
      no_capture <= `PMSNAP_NC_RESET; // RULE_07
    end else if (capture_req) begin
      no_capture <= security_violation; // RULE_05 RULE_06 RULE_07
    end
  end

  // ======================================================================
  // read mux and answer; unmapped addresses also answer with error
  always @* begin
    next_rdata = `PMSNAP_ZERO32;
    next_error = 1'b0;
    if (access_blocked) begin
      next_error = 1'b1; // RULE_03
    end else if (dbg_write) begin
      // only the trigger is writable
      next_error = !trig_hit; // RULE_11
    end else if (evt_range) begin
      next_rdata = evt_held[evt_idx*CNT_W +: CNT_W]; // RULE_10
    end else begin
      case (dbg_addr)
        `PMSNAP_OFF_PC_LO:   next_rdata = pc_view[31:0]; // RULE_01
        `PMSNAP_OFF_PC_HI:   next_rdata = pc_view[63:32]; // RULE_02
        `PMSNAP_OFF_CTX_EL1: next_rdata = live_ctx_el1_sample; // RULE_12
        `PMSNAP_OFF_CTX_EL2: next_rdata = live_ctx_el2_sample; // RULE_12
        `PMSNAP_OFF_STATUS:  next_rdata = {31'h0000_0000, no_capture}; // RULE_04
        `PMSNAP_OFF_OVF:     next_rdata = ovf_held; // RULE_08
        `PMSNAP_OFF_CYC_LO:  next_rdata = cyc_held[31:0]; // RULE_09
        `PMSNAP_OFF_CYC_HI:  next_rdata = cyc_held[63:32]; // RULE_09
        // trigger is write-only, a read of it is an error
        default:             next_error = 1'b1; // RULE_11
      endcase
    end
  end

  // ======================================================================
  // one-cycle answer, registered data
  always @(posedge clk) begin
    if (!rst_b) begin
      dbg_ready     <= 1'b0;
      dbg_error     <= 1'b0;
      dbg_rdata     <= `PMSNAP_ZERO32;
      capture_pulse <= 1'b0;
    end else begin
      dbg_ready     <= take;
      dbg_error     <= take && next_error;
      dbg_rdata     <= take ? next_rdata : `PMSNAP_ZERO32;
      capture_pulse <= capture_req;
    end
  end

endmodule // pmsnap_regs

// [src/pmsnap_defs.vh]
// constants for the performance monitor snapshot register bank
`ifndef PMSNAP_DEFS_VH
`define PMSNAP_DEFS_VH

// ======================================================================
// register offsets (byte addresses in the external debug region)
`define PMSNAP_OFF_PC_LO     12'h0600
`define PMSNAP_OFF_PC_HI     12'h0604
`define PMSNAP_OFF_CTX_EL1   12'h0608
`define PMSNAP_OFF_CTX_EL2   12'h060C
`define PMSNAP_OFF_STATUS    12'h0610
`define PMSNAP_OFF_OVF       12'h0614
`define PMSNAP_OFF_CYC_LO    12'h0618
`define PMSNAP_OFF_CYC_HI    12'h061C
`define PMSNAP_OFF_EVT_BASE  12'h0620
`define PMSNAP_OFF_TRIGGER   12'h06F0

// ======================================================================
// field positions
`define PMSNAP_PC_NS_BIT     63
`define PMSNAP_PC_EL_HI      62
`define PMSNAP_PC_EL_LO      61
`define PMSNAP_PC_ADDR_HI    55
`define PMSNAP_STAT_NC_BIT   0
`define PMSNAP_TRIG_SS_BIT   0

// ======================================================================
// reset values and widths
`define PMSNAP_NC_RESET      1'b1
`define PMSNAP_ZERO32        32'h0000_0000
`define PMSNAP_ZERO5         5'h00
`define PMSNAP_EVT_COUNT     6
`define PMSNAP_EVT_IDX_W     3
`define PMSNAP_WORD_SHIFT    2

`endif

// [src/pmsnap_capture_reg.v]
// one capture register that loads its source on a capture strobe
`timescale 1ns/10ps

module pmsnap_capture_reg #(
  parameter WIDTH = 32
) (
  input  wire             clk,
  input  wire             rst_b,
  input  wire             load,
  input  wire [WIDTH-1:0] src,
  output reg  [WIDTH-1:0] held
);

  // ======================================================================
  // storage
  // copy is touched only by reset and load, so later writes to the live
  // counters cannot disturb it
  always @(posedge clk) begin
    if (!rst_b) begin
      held <= {WIDTH{1'b0}};
    end else if (load) begin
      held <= src;
    end
  end

endmodule // pmsnap_capture_reg

// [test/pmsnap_regs_checker.sv]
// port assertions for the snapshot register bank
`timescale 1ns/10ps
// ======
// checker
module pmsnap_regs_checker (
  input wire        clk,
  input wire        rst_b,
  input wire        dbg_sel,
  input wire        dbg_write,
  input wire [11:0] dbg_addr,
  input wire [31:0] dbg_wdata,
  input wire        dbg_ready,
  input wire        dbg_error,
  input wire [31:0] dbg_rdata,
  input wire        core_power_on,
  input wire        double_lock_active,
  input wire        capture_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire take = dbg_sel && !dbg_ready;
  wire up   = core_power_on && !double_lock_active;
  sequence s_trig; take && up && dbg_write && dbg_addr == 12'h06F0; endsequence
  sequence s_stat; take && up && !dbg_write && dbg_addr == 12'h0610; endsequence
  property p_answer; take |=> dbg_ready; endproperty
  a_answer: assert property (p_answer) else $error("late answer");
  property p_cause; dbg_ready |-> $past(take); endproperty
  a_cause: assert property (p_cause) else $error("unasked answer");
  property p_idle; !dbg_ready |-> dbg_rdata == 32'h0000_0000 && !dbg_error;
  endproperty
  a_idle: assert property (p_idle) else $error("data outside answer");
  property p_shut; take && !up |=> dbg_error && !capture_pulse; endproperty
  a_shut: assert property (p_shut) else $error("locked access ok");
  property p_cap; s_trig ##0 dbg_wdata[0] |=> capture_pulse && !dbg_error;
  endproperty
  a_cap: assert property (p_cap) else $error("no capture");
  property p_nocap; s_trig ##0 !dbg_wdata[0] |=> !capture_pulse && !dbg_error;
  endproperty
  a_nocap: assert property (p_nocap) else $error("zero captured");
  property p_stat; s_stat |=> dbg_rdata[31:1] == 31'h0000_0000 && !dbg_error;
  endproperty
  a_stat: assert property (p_stat) else $error("status high bits");
  property p_pulse; capture_pulse |-> $past(take && up && dbg_wdata[0]);
  endproperty
  a_pulse: assert property (p_pulse) else $error("stray capture");
endmodule // pmsnap_regs_checker

bind pmsnap_regs pmsnap_regs_checker u_chk (.*);

// [test/pmsnap_core_model.sv]
// core side model: live counters that move only when stepped
`timescale 1ns/10ps
module pmsnap_core_model (
  input  wire         clk,
  input  wire         rst_b,
  input  wire         step,
  output wire [31:0]  overflow_status,
  output wire [63:0]  cycle_counter,
  output wire [191:0] event_counter
);
  reg [31:0] cnt;
  // stepping stands in for later counter writes, so copies are predictable
  always @(posedge clk) cnt <= !rst_b ? 32'h0000_0100 : cnt + step;
  assign overflow_status = {cnt[15:0], ~cnt[15:0]};
  assign cycle_counter   = {~cnt, cnt};
  assign event_counter   = {cnt + 5, cnt + 4, cnt + 3, cnt + 2, cnt + 1, cnt};
endmodule // pmsnap_core_model

// [test/pmsnap_regs_bench.sv]
// self-checking bench for the snapshot register bank
`timescale 1ns/10ps
module pmsnap_regs_bench;
  reg clk = 0, rst_b = 0, dbg_sel = 0, dbg_write = 0, step = 0, er, cp;
  reg core_power_on = 1, double_lock_active = 0, security_violation = 0;
  reg nonsecure_sample_flag = 1;
  reg [1:0] exception_level_sample = 2'h2;
  reg [11:0] dbg_addr = 12'h000;
  reg [31:0] dbg_wdata = 32'h0000_0000, rd, ecnt = 32'h0000_0100;
  reg [31:0] live_ctx_el1_sample = 32'h0C1D_0001;
  reg [31:0] live_ctx_el2_sample = 32'h0C1D_0002;
  reg [55:0] live_pc_sample = 56'h12_3456_789A_BCDE;
  wire dbg_ready, dbg_error, capture_pulse;
  wire [31:0] dbg_rdata, overflow_status;
  wire [63:0] cycle_counter;
  wire [191:0] event_counter;
  integer fail_count = 0, n_checks = 0, i, k;
  always #20 clk = ~clk;
  pmsnap_regs dut (.*);
  pmsnap_core_model core (.*);
  // ======
  // tasks
  task stop_test; begin
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  end endtask
  task chk(input [31:0] g, input [31:0] e); begin
    n_checks = n_checks + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  end endtask
  // one access: drive it, wait up to 4 cycles for dbg_ready, keep its data, error and capture pulse
  task acc(input w, input [11:0] a, input [31:0] d); begin
    dbg_write = w; dbg_addr = a; dbg_wdata = d; dbg_sel = 1;
    i = 0;
    do begin @(posedge clk); #1; i = i + 1; end
    while (dbg_ready !== 1'b1 && i < 4);
    if (dbg_ready !== 1'b1) begin fail_count = fail_count + 1; stop_test; end
    rd = dbg_rdata; er = dbg_error; cp = capture_pulse; dbg_sel = 0;
    @(posedge clk); #1;
  end endtask
  task rdc(input [11:0] a, input [31:0] e); begin
    acc(0, a, 0); chk(er, 0); chk(rd, e);
  end endtask
  task rd_cnts(input [31:0] c); begin
    rdc(12'h0614, {c[15:0], ~c[15:0]});
    rdc(12'h0618, c);
    rdc(12'h061C, ~c);
    for (k = 0; k < 6; k = k + 1) rdc(12'h0620 + 4 * k, c + k);
  end endtask
  task cap(input v); begin
    security_violation = v; acc(1, 12'h06F0, 32'h0000_0001);
    security_violation = 0; chk(cp, 1);
  end endtask
  task bump(input [7:0] n); begin
    step = 1; repeat (n) @(posedge clk); #1; step = 0; ecnt = ecnt + n;
  end endtask
  // ======
  // scenarios
  task t_pc; begin
    rdc(12'h0600, live_pc_sample[31:0]);
    rdc(12'h0604, {3'h6, 5'h00, live_pc_sample[55:32]});
    rdc(12'h0608, live_ctx_el1_sample);
    rdc(12'h060C, live_ctx_el2_sample);
    nonsecure_sample_flag = 0; live_pc_sample = 56'hFE_DCBA_9876_5432;
    rdc(12'h0604, {8'h40, 24'hFE_DCBA});
    $display("pc test done");
  end endtask
  task t_capture; begin
    rdc(12'h0610, 1);
    bump(3); cap(0); rdc(12'h0610, 0);
    rd_cnts(ecnt);
    bump(7); acc(1, 12'h06F0, 0); chk(cp, 0); chk(er, 0);
    rd_cnts(ecnt - 7);
    cap(1); rdc(12'h0610, 1); rd_cnts(ecnt - 7);
    $display("capture test done");
  end endtask
  task t_lock; begin
    core_power_on = 0; acc(1, 12'h06F0, 1); chk(er, 1); chk(cp, 0);
    core_power_on = 1; double_lock_active = 1;
    acc(0, 12'h0620, 0); chk(er, 1);
    double_lock_active = 0; rdc(12'h0610, 1);
    acc(1, 12'h0610, 1); chk(er, 1);
    acc(0, 12'h06F0, 0); chk(er, 1);
    acc(0, 12'h0700, 0); chk(er, 1);
    $display("lock test done");
  end endtask
  initial begin
    repeat (20) @(posedge clk);
    #1 rst_b = 1;
    @(posedge clk); #1;
    t_pc; t_capture; t_lock;
    stop_test;
  end
endmodule // pmsnap_regs_bench
